// >>> logic/cad_decoder.sv
// addressing-mode decoder and flag effects, with wishbone register access
`timescale 1ns/1ps
module cad_decoder
    import cad_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // memory read port for pointer fetch
    output logic mem_rd_o,
    output logic [ADDR_W-1:0] mem_adr_o,
    input wire logic mem_ack_i,
    input wire logic [7:0] mem_dat_i,
    // core hooks
    input wire logic irq_i,
    output logic wait_o,
    output logic osc_stop_o,
    output logic [ADDR_W-1:0] ea_o,
    output logic ea_valid_o,
    output logic [7:0] result_o,
    output logic result_wr_o
);
    typedef enum logic [2:0] {
        CAD_S_IDLE = 3'b000,
        CAD_S_FETCH = 3'b001,
        CAD_S_PTR_HI = 3'b010,
        CAD_S_PTR_LO = 3'b011,
        CAD_S_DONE = 3'b100
    } cad_state_t;

    cad_state_t state_q, state_d;
    logic [7:0] opc_q;
    logic idx_sel_q;
    logic [7:0] idx_x_q, idx_y_q;
    logic [7:0] flags_q;
    logic [1:0] need_q, got_q;
    logic [15:0] opnd_q;
    logic [15:0] ptr_q;
    logic [ADDR_W-1:0] ea_q;
    logic ea_valid_q;
    logic ill_q, wait_q, halt_q;
    logic [1:0] len_q;
    logic [7:0] res_q;
    logic res_wr_q;
    logic ack_q;
    logic [31:0] rdat_q;

    // bus decode
    wire logic acc = wb_cyc_i & wb_stb_i & ~ack_q;
    wire logic wr_ctrl = acc & wb_we_i & (wb_adr_i == CAD_REG_CTRL) &
                         wb_sel_i[0];
    wire logic wr_opnd = acc & wb_we_i & (wb_adr_i == CAD_REG_OPND) &
                         wb_sel_i[0];
    wire logic wr_idx = wr_ctrl & wb_sel_i[3];
    wire logic [7:0] new_opc = wb_dat_i[7:0];
    wire logic [3:0] new_mode = new_opc[7:4];
    wire logic [3:0] new_op = new_opc[3:0];
    wire logic start = wr_ctrl & (state_q == CAD_S_IDLE) & ~halt_q;

    // operand byte count per addressing mode
    function automatic logic [1:0] opnd_bytes(input logic [3:0] m);
        unique case (m)
            CAD_M_INH, CAD_M_IDX_N: opnd_bytes = 2'd0;
            CAD_M_IMM, CAD_M_DIR_S, CAD_M_IDX_S,
            CAD_M_IND_S, CAD_M_IND_L: opnd_bytes = 2'd1;
            CAD_M_DIR_L, CAD_M_IDX_L: opnd_bytes = 2'd2;
            default: opnd_bytes = 2'd0;
        endcase
    endfunction

    wire logic new_ill = (new_mode > CAD_M_IND_L);

    // shift unit operating on the operand byte
    cad_flagres_t sh;
    cad_shift_unit cad_shift_unit_i (
        .op_i(opc_q[3:0]),
        .dst_i(opnd_q[7:0]),
        .carry_i(flags_q[CAD_FLG_C]),
        .out_o(sh)
    );

    wire logic [7:0] idx = idx_sel_q ? idx_y_q : idx_x_q;
    wire logic [ADDR_W-1:0] idx_w = ADDR_W'(idx);
    wire logic done_fetch = (got_q == need_q);
    wire logic [3:0] cur_mode = opc_q[7:4];

    // effective address before any pointer fetch
    logic [ADDR_W-1:0] ea_calc;
    always_comb begin
        ea_calc = '0;
        unique case (cur_mode)
            CAD_M_DIR_S: ea_calc = ADDR_W'(opnd_q[7:0]);
            CAD_M_DIR_L: ea_calc = ADDR_W'(opnd_q);
            CAD_M_IDX_N: ea_calc = idx_w;
            CAD_M_IDX_S: ea_calc = idx_w + ADDR_W'(opnd_q[7:0]);
            CAD_M_IDX_L: ea_calc = idx_w + ADDR_W'(opnd_q);
            default: ea_calc = '0;
        endcase
    end

    wire logic is_ind = (cur_mode == CAD_M_IND_S) |
                        (cur_mode == CAD_M_IND_L);
    wire logic is_inh = (cur_mode == CAD_M_INH);

    // state transitions
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            CAD_S_IDLE: if (start && !new_ill) begin
                state_d = (opnd_bytes(new_mode) == 2'd0) ? CAD_S_DONE :
                          CAD_S_FETCH;
            end
            CAD_S_FETCH: if (done_fetch) begin
                state_d = !is_ind ? CAD_S_DONE :
                          (cur_mode == CAD_M_IND_L) ? CAD_S_PTR_HI :
                          CAD_S_PTR_LO;
            end
            CAD_S_PTR_HI: if (mem_ack_i) state_d = CAD_S_PTR_LO;
            CAD_S_PTR_LO: if (mem_ack_i) state_d = CAD_S_DONE;
            CAD_S_DONE: state_d = CAD_S_IDLE;
            default: state_d = CAD_S_IDLE;
        endcase
    end

    // pointer fetch address: pointer byte address, +1 for low byte of word
    assign mem_rd_o = (state_q == CAD_S_PTR_HI) | (state_q == CAD_S_PTR_LO);
    assign mem_adr_o = (state_q == CAD_S_PTR_LO && cur_mode == CAD_M_IND_L) ?
                       ADDR_W'(opnd_q[7:0]) + ADDR_W'(1) :
                       ADDR_W'(opnd_q[7:0]);

    // sequencer and operand collection
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= CAD_S_IDLE;
            opc_q <= 8'h00;
            need_q <= 2'd0;
            got_q <= 2'd0;
            opnd_q <= 16'h0000;
            ptr_q <= 16'h0000;
            len_q <= 2'd0;
            ill_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (start) begin
                opc_q <= new_opc;
                idx_sel_q <= wb_dat_i[CAD_CTRL_IDXSEL_BIT];
                need_q <= opnd_bytes(new_mode);
                got_q <= 2'd0;
                opnd_q <= {8'h00, wb_dat_i[23:16]}; // inherent data byte
                len_q <= 2'd1 + opnd_bytes(new_mode);
                ill_q <= new_ill;
            end else if (wr_opnd && state_q == CAD_S_FETCH && !done_fetch) begin
                opnd_q <= {opnd_q[7:0], wb_dat_i[7:0]}; // high byte first
                got_q <= got_q + 2'd1;
            end
            if (state_q == CAD_S_PTR_HI && mem_ack_i) begin
                ptr_q[15:8] <= mem_dat_i;
            end
            if (state_q == CAD_S_PTR_LO && mem_ack_i) begin
                ptr_q[7:0] <= mem_dat_i;
                if (cur_mode == CAD_M_IND_S) ptr_q[15:8] <= 8'h00;
            end
        end
    end

    // effective address and index registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ea_q <= '0;
            ea_valid_q <= 1'b0;
            idx_x_q <= 8'h00;
            idx_y_q <= 8'h00;
        end else begin
            ea_valid_q <= 1'b0;
            if (wr_idx) begin
                if (wb_dat_i[CAD_CTRL_IDXSEL_BIT]) idx_y_q <= wb_dat_i[31:24];
                else idx_x_q <= wb_dat_i[31:24];
            end
            if (state_q == CAD_S_DONE && !is_inh &&
                cur_mode != CAD_M_IMM) begin
                ea_q <= is_ind ? ADDR_W'(ptr_q) : ea_calc;
                ea_valid_q <= 1'b1;
            end
        end
    end

    // flag effects and power states for inherent operations
    wire logic do_inh = (state_q == CAD_S_DONE) & is_inh;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_q <= CAD_FLG_RESET;
            wait_q <= 1'b0;
            halt_q <= 1'b0;
            res_q <= 8'h00;
            res_wr_q <= 1'b0;
        end else begin
            res_wr_q <= 1'b0;
            if (wait_q && irq_i) wait_q <= 1'b0;
            if (wr_ctrl && wb_dat_i[15]) halt_q <= 1'b0; // wake from halt
            if (do_inh) begin
                unique case (opc_q[3:0])
                    CAD_OP_WAIT_IRQ: begin
                        flags_q[CAD_FLG_I] <= 1'b0;
                        wait_q <= 1'b1;
                    end
                    CAD_OP_HALT: halt_q <= 1'b1;
                    CAD_OP_SIM: flags_q[CAD_FLG_I] <= 1'b1;
                    CAD_OP_RIM: flags_q[CAD_FLG_I] <= 1'b0;
                    CAD_OP_SCF: flags_q[CAD_FLG_C] <= 1'b1;
                    CAD_OP_RCF: flags_q[CAD_FLG_C] <= 1'b0;
                    CAD_OP_POPCC: begin
                        flags_q <= opnd_q[7:0] & CAD_FLG_POP_MASK;
                    end
                    CAD_OP_PUSH, CAD_OP_POP, CAD_OP_NOP: ; // flags kept
                    default: begin
                        if (sh.n_wr) flags_q[CAD_FLG_N] <= sh.n;
                        if (sh.z_wr) flags_q[CAD_FLG_Z] <= sh.z;
                        if (sh.c_wr) flags_q[CAD_FLG_C] <= sh.c;
                        res_q <= sh.res;
                        res_wr_q <= sh.c_wr; // tnz raises no result strobe
                    end
                endcase
            end
        end
    end

    // status word
    wire logic [31:0] stat_w = {8'h00, 4'h0, cur_mode, flags_q, 2'b00, len_q,
                                halt_q, wait_q, ill_q,
                                (state_q != CAD_S_IDLE)};
    wire logic [31:0] rd_mux =
        (wb_adr_i == CAD_REG_STAT) ? stat_w :
        (wb_adr_i == CAD_REG_EA) ? 32'(ea_q) :
        (wb_adr_i == CAD_REG_CTRL) ? {idx_y_q, idx_x_q, 8'h00, opc_q} :
        32'h0000_0000; // unmapped reads zero

    // single-cycle wishbone answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= acc;
            if (acc && !wb_we_i) rdat_q <= rd_mux;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign wait_o = wait_q;
    assign osc_stop_o = halt_q;
    assign ea_o = ea_q;
    assign ea_valid_o = ea_valid_q;
    assign result_o = res_q;
    assign result_wr_o = res_wr_q;
endmodule : cad_decoder

// >>> logic/cad_pkg.sv
// package: opcodes, modes, flag positions and bus constants for the decoder
package cad_pkg;
    // register byte addresses on the wishbone slave
    localparam logic [3:0] CAD_REG_CTRL = 4'h0;   // write: opcode issue
    localparam logic [3:0] CAD_REG_OPND = 4'h4;   // write: fetched byte feed
    localparam logic [3:0] CAD_REG_STAT = 4'h8;   // read: state, flags, length
    localparam logic [3:0] CAD_REG_EA = 4'hc;     // read: effective address
    // field positions inside registers
    localparam int CAD_CTRL_IDXSEL_BIT = 8;
    localparam int CAD_CTRL_FLAGS_LSB = 16;
    localparam int CAD_STAT_BUSY_BIT = 0;
    localparam int CAD_STAT_ILL_BIT = 1;
    localparam int CAD_STAT_WAIT_BIT = 2;
    localparam int CAD_STAT_HALT_BIT = 3;
    localparam int CAD_STAT_LEN_LSB = 4;
    localparam int CAD_STAT_FLG_LSB = 8;
    localparam int CAD_STAT_MODE_LSB = 16;
    // condition_code_reg bit positions
    localparam int CAD_FLG_C = 0;
    localparam int CAD_FLG_Z = 1;
    localparam int CAD_FLG_N = 2;
    localparam int CAD_FLG_I = 3;
    localparam int CAD_FLG_H = 4;
    localparam logic [7:0] CAD_FLG_RESET = 8'h08;  // interrupts masked
    localparam logic [7:0] CAD_FLG_POP_MASK = 8'h1f;
    // addressing mode codes (upper nibble of opcode)
    typedef enum logic [3:0] {
        CAD_M_INH = 4'h0,
        CAD_M_IMM = 4'h1,
        CAD_M_DIR_S = 4'h2,
        CAD_M_DIR_L = 4'h3,
        CAD_M_IDX_N = 4'h4,
        CAD_M_IDX_S = 4'h5,
        CAD_M_IDX_L = 4'h6,
        CAD_M_IND_S = 4'h7,
        CAD_M_IND_L = 4'h8
    } cad_mode_t;
    // inherent operation codes (lower nibble when mode is inherent)
    localparam logic [3:0] CAD_OP_NOP = 4'h0;
    localparam logic [3:0] CAD_OP_WAIT_IRQ = 4'h1;
    localparam logic [3:0] CAD_OP_HALT = 4'h2;
    localparam logic [3:0] CAD_OP_SIM = 4'h3;
    localparam logic [3:0] CAD_OP_RIM = 4'h4;
    localparam logic [3:0] CAD_OP_SCF = 4'h5;
    localparam logic [3:0] CAD_OP_RCF = 4'h6;
    localparam logic [3:0] CAD_OP_PUSH = 4'h7;
    localparam logic [3:0] CAD_OP_POP = 4'h8;
    localparam logic [3:0] CAD_OP_POPCC = 4'h9;
    localparam logic [3:0] CAD_OP_TNZ = 4'ha;
    localparam logic [3:0] CAD_OP_SHL = 4'hb;
    localparam logic [3:0] CAD_OP_SHR = 4'hc;
    localparam logic [3:0] CAD_OP_ASR = 4'hd;
    localparam logic [3:0] CAD_OP_ROL = 4'he;
    localparam logic [3:0] CAD_OP_ROR = 4'hf;
    // shifter result bundle
    typedef struct packed {
        logic [7:0] res;
        logic n;
        logic z;
        logic c;
        logic n_wr;
        logic z_wr;
        logic c_wr;
    } cad_flagres_t;
endpackage : cad_pkg

// >>> logic/cad_shift_unit.sv
// shift, rotate and test unit: computes result and n/z/c flag effects
`timescale 1ns/1ps
module cad_shift_unit
    import cad_pkg::*;
(
    input wire logic [3:0] op_i,
    input wire logic [7:0] dst_i,
    input wire logic carry_i,
    output cad_flagres_t out_o
);
    logic [7:0] res;
    logic cout;
    logic nflag;
    logic is_shift;
    logic is_tnz;
    // result and shifted-out bit per operation
    always_comb begin
        res = dst_i;
        cout = carry_i;
        unique case (op_i)
            CAD_OP_SHL: begin
                res = {dst_i[6:0], 1'b0};
                cout = dst_i[7];
            end
            CAD_OP_SHR: begin
                res = {1'b0, dst_i[7:1]};
                cout = dst_i[0];
            end
            CAD_OP_ASR: begin
                res = {dst_i[7], dst_i[7:1]}; // bit 7 replicated
                cout = dst_i[0];
            end
            CAD_OP_ROL: begin
                res = {dst_i[6:0], carry_i};
                cout = dst_i[7];
            end
            CAD_OP_ROR: begin
                res = {carry_i, dst_i[7:1]};
                cout = dst_i[0];
            end
            default: begin
                res = dst_i;
                cout = carry_i;
            end
        endcase
    end
    // flag selection
    assign is_shift = (op_i >= CAD_OP_SHL);
    assign is_tnz = (op_i == CAD_OP_TNZ);
    assign nflag = (op_i == CAD_OP_SHR) ? 1'b0 : res[7];
    assign out_o.res = res;
    assign out_o.n = nflag;
    assign out_o.z = (res == 8'h00);
    assign out_o.c = cout;
    assign out_o.n_wr = is_shift | is_tnz;
    assign out_o.z_wr = is_shift | is_tnz;
    assign out_o.c_wr = is_shift; // tnz leaves carry alone
endmodule : cad_shift_unit

// >>> dv/cad_mem_model.sv
// memory model answering the decoder's pointer reads
`timescale 1ns/1ps
module cad_mem_model (
    input wire logic clk_i,
    input wire logic [3:0] dly_i,
    input wire logic rd_i,
    input wire logic [15:0] adr_i,
    output logic ack_o,
    output logic [7:0] dat_o
);
    int cnt = 0;
    logic ack_q = 1'b0; // quiet bus at time zero
    logic [7:0] dat_q = 8'h00;
    // answer after dly_i waiting cycles; contents are a function of address
    always @(posedge clk_i) begin
        if (rd_i && !ack_q && cnt >= int'(dly_i)) begin
            ack_q <= 1'b1;
            dat_q <= adr_i[7:0] ^ 8'ha5;
            cnt <= 0;
        end else begin
            ack_q <= 1'b0;
            dat_q <= ~dat_q; // stale data never repeats the last value
            cnt <= rd_i ? cnt + 1 : 0;
        end
    end
    // one driver per output
    assign ack_o = ack_q;
    assign dat_o = dat_q;
endmodule : cad_mem_model

// >>> dv/cad_decoder_chk.sv
// assertions on decoder port timing, bound to the decoder
`timescale 1ns/1ps
module cad_decoder_chk
    import cad_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic mem_rd_o,
    input wire logic [ADDR_W-1:0] mem_adr_o,
    input wire logic mem_ack_i,
    input wire logic irq_i,
    input wire logic wait_o,
    input wire logic osc_stop_o,
    input wire logic ea_valid_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // control write that asks to leave halt
    wire logic wake_wr = wb_cyc_i && wb_stb_i && wb_we_i
        && wb_adr_i == CAD_REG_CTRL && wb_dat_i[15];
    // bus answers one cycle after the request, ack is a pulse
    property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("ack late");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
    // pointer reads: held, address at most 256, second byte follows the first
    property p_rd_hold; mem_rd_o && !mem_ack_i |=> mem_rd_o
        && $stable(mem_adr_o); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read dropped");
    property p_ptr_range; mem_rd_o |-> mem_adr_o <= ADDR_W'(256); endproperty
    a_ptr_range: assert property (p_ptr_range) else $error("ptr range");
    property p_ptr_next; mem_rd_o && mem_ack_i ##1 mem_rd_o |->
        mem_adr_o == ADDR_W'($past(mem_adr_o) + 1); endproperty
    a_ptr_next: assert property (p_ptr_next) else $error("ptr order");
    property p_rd_done; mem_rd_o && mem_ack_i ##1 !mem_rd_o |->
        ##[0:3] ea_valid_o; endproperty
    a_rd_done: assert property (p_rd_done) else $error("no address");
    // low-power states: wait ends only by interrupt, halt only by wake write
    property p_wake; wait_o && irq_i |-> ##[1:4] !wait_o; endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_wait_hold; wait_o && !irq_i |=> wait_o; endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("wait lost");
    property p_halt_hold; osc_stop_o && !wake_wr |=> osc_stop_o; endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("halt lost");
endmodule : cad_decoder_chk

bind cad_decoder cad_decoder_chk #(.ADDR_W(ADDR_W)) cad_decoder_chk_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .mem_rd_o(mem_rd_o), .mem_adr_o(mem_adr_o),
    .mem_ack_i(mem_ack_i), .irq_i(irq_i), .wait_o(wait_o),
    .osc_stop_o(osc_stop_o), .ea_valid_o(ea_valid_o));

// >>> dv/tb_cad_decoder.sv
// self-checking bench for the addressing-mode decoder
`timescale 1ns/1ps
module tb_cad_decoder;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic irq = 1'b0, ack, mrd, mack, wt, hlt, eav, rwr;
    logic [3:0] adr = 4'h0, sel = 4'h0, dly = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [15:0] madr, ea, ea_seen;
    logic [7:0] mdat, res, res_seen;
    int err_count = 0, check_count = 0, n_res = 0;
    cad_decoder cad_decoder_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .mem_rd_o(mrd),
        .mem_adr_o(madr), .mem_ack_i(mack), .mem_dat_i(mdat), .irq_i(irq),
        .wait_o(wt), .osc_stop_o(hlt), .ea_o(ea), .ea_valid_o(eav),
        .result_o(res), .result_wr_o(rwr));
    cad_mem_model cad_mem_model_i (.clk_i(clk_i), .dly_i(dly), .rd_i(mrd),
        .adr_i(madr), .ack_o(mack), .dat_o(mdat));
    // 100 MHz clock
    initial forever #5 clk_i = ~clk_i;
    // capture what the decoder reports on its strobes
    always @(posedge clk_i) begin
        if (eav === 1'b1) ea_seen <= ea;
        if (rwr === 1'b1) begin
            res_seen <= res;
            n_res <= n_res + 1;
        end
    end
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude
    task automatic give_up();
        err_count++;
        conclude();
    endtask : give_up
    // one classic wishbone cycle; read data lands in q
    task automatic bus(logic w, logic [3:0] a, logic [31:0] d, logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) give_up();
    endtask : bus
    // bounded wait for a level on a decoder output
    task automatic hold_for(ref logic s, input logic v);
        for (int i = 0; i < 50; i++) begin
            @(posedge clk_i);
            if (s === v) return;
        end
        give_up();
    endtask : hold_for
    // poll status until not busy, q keeps the last status
    task automatic idle();
        for (int i = 0; i < 50; i++) begin
            bus(1'b0, 4'h8, 32'h0, 4'hf);
            if (q[0] === 1'b0) return;
        end
        give_up();
    endtask : idle
    // issue an opcode, feed operand bytes high first, wait for completion
    task automatic run(logic [31:0] c, logic [3:0] nb, logic [15:0] v);
        bus(1'b1, 4'h0, c, 4'h7);
        if (nb == 4'h2) bus(1'b1, 4'h4, {24'h0, v[15:8]}, 4'h1);
        if (nb != 4'h0) bus(1'b1, 4'h4, {24'h0, v[7:0]}, 4'h1);
        idle();
    endtask : run
    task automatic t_reset();
        bus(1'b0, 4'h8, 32'h0, 4'hf);
        chk("status", q, 32'h800);
        bus(1'b1, 4'h6, 32'hffffffff, 4'hf);
        bus(1'b0, 4'h6, 32'h0, 4'hf);
        chk("unmapped", q, 32'h0);
        chk("pins", {wt, hlt}, 32'h0);
        $display("test reset done");
    endtask : t_reset
    // every addressing mode: ctrl, operand bytes, operand, address, length
    task automatic t_modes();
        logic [55:0] t[9] = '{56'h0000_0_0000_0000_1, 56'h0010_1_003c_0000_2,
            56'h0020_1_0080_0080_2, 56'h0030_2_beef_beef_3,
            56'h0040_0_0000_00ff_1, 56'h0050_1_00ff_01fe_2,
            56'h0160_2_1234_1246_3, 56'h0070_1_0040_00e5_2,
            56'h0080_1_0050_f5f4_2};
        bus(1'b1, 4'h0, 32'hff000000, 4'hf);
        idle();
        bus(1'b1, 4'h0, 32'h12000100, 4'hf);
        idle();
        for (int i = 0; i < 9; i++) begin
            dly <= (i == 8) ? 4'h3 : 4'h0;
            run({16'h0, t[i][55:40]}, t[i][39:36], t[i][35:20]);
            chk("mode len", {q[19:16], q[5:4]}, {4'(i), t[i][1:0]});
            if (i > 1) begin
                bus(1'b0, 4'hc, 32'h0, 4'hf);
                chk("ea reg", q, t[i][19:4]);
                chk("ea pin", ea_seen, t[i][19:4]);
            end
        end
        run(32'h90, 4'h0, 16'h0);
        chk("illegal", q[1], 32'h1);
        run(32'h0, 4'h0, 16'h0);
        chk("legal", q[1], 32'h0);
        run(32'hf0, 4'h0, 16'h0);
        chk("illegal", q[1], 32'h1);
        $display("test modes done");
    endtask : t_modes
    // inherent flag ops: op, data byte, flags after, shift result
    task automatic t_flags();
        logic [27:0] t[16] = '{28'h5000900, 28'h6000800, 28'h4000000,
            28'h3000800, 28'h9ff1f00, 28'h7001f00, 28'h8001f00, 28'ha001b00,
            28'ha801d00, 28'hb811902, 28'hc011b00, 28'hd811dc0, 28'he801901,
            28'h6001800, 28'hf011b00, 28'hf001c80};
        int k;
        for (int i = 0; i < 16; i++) begin
            k = n_res;
            run({8'h0, t[i][23:16], 12'h0, t[i][27:24]}, 4'h0, 16'h0);
            chk("flags", q[15:8], t[i][15:8]);
            if (t[i][27:24] > 4'ha) chk("result", res_seen, t[i][7:0]);
            else chk("no write", n_res, k);
        end
        $display("test flags done");
    endtask : t_flags
    // wait until interrupt, then halt, refused opcode, wake write
    task automatic t_power();
        bus(1'b1, 4'h0, 32'h1, 4'h7);
        hold_for(wt, 1'b1);
        bus(1'b0, 4'h8, 32'h0, 4'hf);
        chk("wait", {q[15:8], q[2]}, {8'h14, 1'b1});
        irq <= 1'b1;
        hold_for(wt, 1'b0);
        irq <= 1'b0;
        idle();
        bus(1'b1, 4'h0, 32'h2, 4'h7);
        hold_for(hlt, 1'b1);
        bus(1'b1, 4'h0, 32'h5, 4'h7);
        bus(1'b0, 4'h8, 32'h0, 4'hf);
        chk("halt", {q[15:8], q[3], hlt}, {8'h14, 2'b11});
        bus(1'b1, 4'h0, 32'h8000, 4'h3);
        hold_for(hlt, 1'b0);
        idle();
        $display("test power done");
    endtask : t_power
    // reset for 20 cycles, then the scenarios
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_modes();
        t_flags();
        t_power();
        conclude();
    end
endmodule : tb_cad_decoder
